// *** core/angle_waveform_calc.sv ***
// electrical angle timer, position capture and three-phase waveform calculator
// assumes a 16-bit register port on the system clock and an async position pin
//
// Contract
// RQ1 - writing one to start bit launches calculation
// RQ2 - busy bit shows calculator idle or running
// RQ3 - sync bit chooses angle-locked automatic starts
// RQ4 - irq source: timer count or calculation end
// RQ5 - direction bit: zero up, one down
// RQ6 - order bit: V,W at plus or minus
// RQ7 - prescale divides clock by 8,16,32,64
// RQ8 - modulation bit: two-phase or three-phase
// RQ9 - transfer bit gates copy to duty registers
// RQ10 - calculation enable gates all calculations
// RQ11 - timer enable gates angle counting
// RQ12 - correction n lengthens n of 16 steps
// RQ13 - software keeps period at least 0x010
// RQ14 - angle register sets start, reads running
// RQ15 - amplitude scales every computed duty value
// RQ16 - position detection latches angle into capture
// RQ17 - twelve-bit duty per phase sets PWM
// RQ18 - sine port bytes fill successive table entries
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module angle_waveform_calc
  import angle_calc_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // register port
  input  wire logic [15:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,
  // position detector pin
  input  wire logic        I_POS_DETECT,
  // duty values towards the PWM compare stage
  output duty_t            O_DUTY,
  output logic             O_DUTY_LOAD,
  // status
  output logic             O_CALC_BUSY,
  output logic             O_IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                        angle_control; // setup bits
    logic                              calc_nosync;   // 1 disables angle-locked starts
    logic                              irq_sel;       // interrupt source choice
    logic [15:0]                       period;        // correction and 1/m period
    logic [ANGLE_W-1:0]                angle;         // running electrical angle
    logic [DUTY_W-1:0]                 amplitude;     // voltage amplitude
    logic [ANGLE_W-1:0]                capture;       // angle at position event
    logic [SINE_DEPTH-1:0][7:0]        sine;          // quarter-wave table
    logic [6:0]                        wptr;          // next table entry to fill
    logic [EV_W-1:0]                   irq_status;    // sticky events
    logic [EV_W-1:0]                   irq_mask;      // event enables
    logic [5:0]                        pre_cnt;       // prescaler
    logic [PERIOD_W-1:0]               step_cnt;      // 1/m counter
    logic [3:0]                        corr_phase;    // position in 16-step correction cycle
    calc_state_t                       calc_state;    // calculator sequence
    logic [1:0]                        phase_idx;     // phase under calculation
    logic [ANGLE_W-1:0]                calc_angle;    // angle frozen at start
    duty_t                             work;          // results in progress
    duty_t                             duty;          // transferred results
    logic                              duty_load;     // one-cycle transfer strobe
    logic [15:0]                       rdata;         // read data, valid one cycle
    logic                              pos_meta;      // synchroniser first stage
    logic                              pos_sync;      // synchroniser second stage
    logic                              pos_last;      // edge detect history
  } state_t;

  state_t s;      // registered state
  state_t next_s; // next state

  // ----------------------------------------------------------------
  // sine lookup: returns {negative, magnitude} for an angle 0..383
  // ----------------------------------------------------------------
  // quadrant two and four mirror the table; the 95-r mirror drops one
  // sample at the peak, which saves a table entry and stays monotonic
  function automatic logic [8:0] sine_of(input logic [ANGLE_W-1:0]     a,
                                         input logic [SINE_DEPTH-1:0][7:0] tbl);
    logic [8:0] r;
    logic [6:0] idx;
    logic       neg;
    logic       mirror;
    r      = a;
    neg    = 1'b0;
    mirror = 1'b0;
    if (a >= 9'h120)
    begin
      r      = a - 9'h120;
      neg    = 1'b1;
      mirror = 1'b1;
    end
    else if (a >= 9'h0c0)
    begin
      r   = a - 9'h0c0;
      neg = 1'b1;
    end
    else if (a >= QUARTER)
    begin
      r      = a - QUARTER;
      mirror = 1'b1;
    end
    idx = mirror ? (SINE_LAST - r[6:0]) : r[6:0];
    return {neg, tbl[idx]};
  endfunction

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic                wr_ac;       // write to angle control
  logic                wr_cc;       // write to calc control
  logic                tmr_en;      // timer running
  logic                calc_en;     // calculator allowed
  logic [5:0]          pre_mask;    // prescaler terminal pattern
  logic                pre_tick;    // one-cycle prescaled enable
  logic [12:0]         limit;       // steps of 1/m counter this angle step
  logic                step;        // angle advances this cycle
  logic                pos_edge;    // rising edge of synchronised detector
  logic [EV_W-1:0]     ev;          // events this cycle
  logic [EV_W-1:0]     ev_clr;      // write-one-to-clear bits
  logic                start_req;   // calculation request
  logic [9:0]          ph_off;      // phase offset for this phase
  logic [9:0]          ph_sum;      // raw phase angle
  logic [ANGLE_W-1:0]  ph_angle;    // wrapped phase angle
  logic [8:0]          sin_val;     // sign and magnitude
  logic [19:0]         product;     // amplitude times sine
  logic [DUTY_W-1:0]   duty_one;    // duty for this phase
  logic [DUTY_W-1:0]   duty_min;    // smallest of three, for two-phase
  logic [EV_W-1:0]     src_gate;    // interrupt source selection

  assign wr_ac   = I_WR && (I_ADDR == ADDR_ANGLE_CONTROL);
  assign wr_cc   = I_WR && (I_ADDR == ADDR_CALC_CONTROL);
  assign tmr_en  = s.angle_control[AC_TMR_EN];
  assign calc_en = s.angle_control[AC_CALC_EN];

  // prescale pattern per select code
  always_comb
  begin
    case (s.angle_control[AC_PRE_HI:AC_PRE_LO]) // RQ7
      2'h0:    pre_mask = 6'h07;
      2'h1:    pre_mask = 6'h0f;
      2'h2:    pre_mask = 6'h1f;
      default: pre_mask = 6'h3f;
    endcase
  end

  assign pre_tick = tmr_en && ((s.pre_cnt & pre_mask) == pre_mask);

  // n of every 16 angle steps take one extra 1/m count
  assign limit = {1'b0, s.period[PERIOD_W-1:0]} +
                 ((s.corr_phase < s.period[PER_CORR_HI:PER_CORR_LO]) ? 13'h0001 : 13'h0000); // RQ12

  // the period floor is the writer's duty; a zero period still steps every tick
  assign step = pre_tick && ((13'(s.step_cnt) + 13'h0001) >= limit); // RQ13

  // only the second stage feeds the edge detector
  assign pos_edge = s.pos_sync && !s.pos_last;

  // software start or angle-locked start
  assign start_req = (wr_cc && I_WDATA[CC_START]) || (step && !s.calc_nosync); // RQ1 RQ3

  // phase offsets: V and W lead or lag U by a third of a turn
  always_comb
  begin
    case (s.phase_idx) // RQ6
      2'h1:    ph_off = s.angle_control[AC_ORDER] ? (ANGLE_STEPS - ANGLE_THIRD) : ANGLE_THIRD;
      2'h2:    ph_off = s.angle_control[AC_ORDER] ? ANGLE_THIRD : (ANGLE_STEPS - ANGLE_THIRD);
      default: ph_off = 10'h000;
    endcase
  end

  assign ph_sum   = {1'b0, s.calc_angle} + ph_off;
  assign ph_angle = (ph_sum >= ANGLE_STEPS) ? 9'(ph_sum - ANGLE_STEPS) : ph_sum[8:0];
  assign sin_val  = sine_of(ph_angle, s.sine);

  // amplitude scales the sine; top bits keep the swing within half range
  assign product  = s.amplitude * sin_val[7:0]; // RQ15
  assign duty_one = sin_val[8] ? (DUTY_MID - {1'b0, product[19:9]})
                               : (DUTY_MID + {1'b0, product[19:9]});

  // smallest phase, used to clamp one phase to zero in two-phase mode
  always_comb
  begin
    duty_min = s.work.u;
    if (s.work.v < duty_min)
    begin
      duty_min = s.work.v;
    end
    if (s.work.w < duty_min)
    begin
      duty_min = s.work.w;
    end
  end

  assign ev_clr   = (I_WR && (I_ADDR == ADDR_IRQ_STATUS)) ? I_WDATA[EV_W-1:0] : 3'h0;
  assign src_gate = {1'b1, s.irq_sel, !s.irq_sel}; // RQ4

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s           = s;
    next_s.duty_load = 1'b0;
    next_s.rdata     = 16'h0000;
    ev               = 3'h0;

    // two-stage synchroniser on the detector pin
    next_s.pos_meta = I_POS_DETECT;
    next_s.pos_sync = s.pos_meta;
    next_s.pos_last = s.pos_sync;

    // angle timer: prescaler, 1/m counter, angle step
    if (tmr_en) // RQ11
    begin
      next_s.pre_cnt = s.pre_cnt + 6'h01;
      if (step)
      begin
        next_s.step_cnt   = 12'h000;
        next_s.corr_phase = s.corr_phase + 4'h1;
        ev[EV_STEP]       = 1'b1;
        if (s.angle_control[AC_DIR]) // RQ5
        begin
          next_s.angle = (s.angle == 9'h000) ? ANGLE_LAST : s.angle - 9'h001;
        end
        else
        begin
          next_s.angle = (s.angle == ANGLE_LAST) ? 9'h000 : s.angle + 9'h001;
        end
      end
      else if (pre_tick)
      begin
        next_s.step_cnt = s.step_cnt + 12'h001;
      end
    end
    else
    begin
      // stopped timer restarts from a clean count
      next_s.pre_cnt  = 6'h00;
      next_s.step_cnt = 12'h000;
    end

    // position capture
    if (pos_edge)
    begin
      next_s.capture = s.angle; // RQ16
      ev[EV_CAP]     = 1'b1;
    end

    // waveform calculator
    case (s.calc_state)
      CALC_IDLE:
      begin
        if (calc_en && start_req) // RQ10
        begin
          next_s.calc_state = CALC_PHASE;
          next_s.phase_idx  = 2'h0;
          next_s.calc_angle = s.angle;
        end
      end
      CALC_PHASE:
      begin
        // one phase per cycle, frozen angle keeps the three consistent
        case (s.phase_idx)
          2'h0:    next_s.work.u = duty_one;
          2'h1:    next_s.work.v = duty_one;
          default: next_s.work.w = duty_one;
        endcase
        if (s.phase_idx == 2'h2)
        begin
          next_s.calc_state = CALC_MOD;
        end
        else
        begin
          next_s.phase_idx = s.phase_idx + 2'h1;
        end
      end
      CALC_MOD:
      begin
        // two-phase shifts all down so one phase rests at zero
        if (!s.angle_control[AC_THREE]) // RQ8
        begin
          next_s.work.u = s.work.u - duty_min;
          next_s.work.v = s.work.v - duty_min;
          next_s.work.w = s.work.w - duty_min;
        end
        next_s.calc_state = CALC_DONE;
      end
      CALC_DONE:
      begin
        if (s.angle_control[AC_XFER]) // RQ9
        begin
          next_s.duty      = s.work; // RQ17
          next_s.duty_load = 1'b1;
        end
        ev[EV_CALC]       = 1'b1;
        next_s.calc_state = CALC_IDLE;
      end
      default:
      begin
        next_s.calc_state = CALC_IDLE;
      end
    endcase

    // disabling the calculator abandons a calculation in progress
    if (!calc_en && (s.calc_state != CALC_IDLE)) // RQ10
    begin
      next_s.calc_state = CALC_IDLE;
    end

    // register writes; software wins over the timer for the angle
    if (I_WR)
    begin
      case (I_ADDR)
        ADDR_ANGLE_CONTROL: next_s.angle_control = I_WDATA[7:0];
        ADDR_CALC_CONTROL:
        begin
          next_s.calc_nosync = I_WDATA[CC_NOSYNC]; // RQ3
          next_s.irq_sel     = I_WDATA[CC_IRQ_SEL]; // RQ4
        end
        ADDR_ANGLE_PERIOD:  next_s.period = I_WDATA;
        ADDR_ANGLE_VALUE:
        begin
          next_s.angle    = I_WDATA[ANGLE_W-1:0]; // RQ14
          next_s.step_cnt = 12'h000;
        end
        ADDR_AMPLITUDE:     next_s.amplitude = I_WDATA[DUTY_W-1:0];
        ADDR_SINE_PORT:
        begin
          next_s.sine[s.wptr] = I_WDATA[7:0]; // RQ18
          next_s.wptr = (s.wptr == SINE_LAST) ? 7'h00 : s.wptr + 7'h01;
        end
        ADDR_IRQ_MASK:      next_s.irq_mask = I_WDATA[EV_W-1:0];
        default:            next_s.wptr = s.wptr;
      endcase
    end

    // turning the calculator off rewinds the table pointer for a reload
    if (wr_ac && !I_WDATA[AC_CALC_EN])
    begin
      next_s.wptr = 7'h00;
    end

    // sticky events: a new event beats a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~ev_clr) | ev;

    // read data for the following cycle; unmapped reads give zero
    if (I_RD)
    begin
      case (I_ADDR)
        ADDR_ANGLE_CONTROL: next_s.rdata = {8'h00, s.angle_control};
        ADDR_CALC_CONTROL:  next_s.rdata = {13'h0000, (s.calc_state != CALC_IDLE),
                                            s.calc_nosync, s.irq_sel}; // RQ2
        ADDR_ANGLE_PERIOD:  next_s.rdata = s.period;
        ADDR_ANGLE_VALUE:   next_s.rdata = {7'h00, s.angle}; // RQ14
        ADDR_AMPLITUDE:     next_s.rdata = {4'h0, s.amplitude};
        ADDR_ANGLE_CAPTURE: next_s.rdata = {7'h00, s.capture};
        ADDR_IRQ_STATUS:    next_s.rdata = {13'h0000, s.irq_status};
        ADDR_IRQ_MASK:      next_s.rdata = {13'h0000, s.irq_mask};
        default:            next_s.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s               <= '0;
      s.angle_control <= ANGLE_CONTROL_RST;
      s.period        <= PERIOD_RST;
      s.amplitude     <= AMPLITUDE_RST;
      s.calc_state    <= CALC_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_RDATA     = s.rdata;
  assign O_DUTY      = s.duty;
  assign O_DUTY_LOAD = s.duty_load;
  assign O_CALC_BUSY = (s.calc_state != CALC_IDLE); // RQ2
  assign O_IRQ       = |(s.irq_status & s.irq_mask & src_gate); // RQ4

endmodule

// *** inc/angle_calc_pkg.sv ***
// constants and types for the electrical angle timer and waveform calculator
// assumes one system clock; registers sit at their byte offsets on a 16-bit port
package angle_calc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ANGLE_CONTROL = 16'h1fc0; // timer and calculation setup
  localparam logic [15:0] ADDR_CALC_CONTROL  = 16'h1fc1; // start, busy, sync, irq source
  localparam logic [15:0] ADDR_ANGLE_PERIOD  = 16'h1fc2; // correction n and 1/m period
  localparam logic [15:0] ADDR_ANGLE_VALUE   = 16'h1fc4; // initial and running angle
  localparam logic [15:0] ADDR_AMPLITUDE     = 16'h1fc6; // voltage amplitude
  localparam logic [15:0] ADDR_ANGLE_CAPTURE = 16'h1fc8; // angle at position detection
  localparam logic [15:0] ADDR_SINE_PORT     = 16'h1fca; // sine table byte port
  localparam logic [15:0] ADDR_IRQ_STATUS    = 16'h1fcc; // sticky events, write one clears
  localparam logic [15:0] ADDR_IRQ_MASK      = 16'h1fce; // event enables

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AC_DIR      = 7;  // 1 counts down
  localparam int AC_ORDER    = 6;  // 1 reverses phase order
  localparam int AC_PRE_HI   = 5;  // prescale select, upper bit
  localparam int AC_PRE_LO   = 4;  // prescale select, lower bit
  localparam int AC_THREE    = 3;  // 1 three-phase, 0 two-phase modulation
  localparam int AC_XFER     = 2;  // copy results to duty registers
  localparam int AC_CALC_EN  = 1;  // waveform calculation enable
  localparam int AC_TMR_EN   = 0;  // angle timer enable
  localparam int CC_START    = 3;  // write one starts a calculation
  localparam int CC_BUSY     = 2;  // reads one while calculating
  localparam int CC_NOSYNC   = 1;  // 0 starts in step with the angle
  localparam int CC_IRQ_SEL  = 0;  // 0 timer event, 1 calculation end
  localparam int PER_CORR_HI = 15; // correction count n
  localparam int PER_CORR_LO = 12;
  localparam int EV_STEP     = 0;  // angle timer finished a count
  localparam int EV_CALC     = 1;  // calculation finished
  localparam int EV_CAP      = 2;  // position captured

  // ----------------------------------------------------------------
  // widths, geometry, reset values
  // ----------------------------------------------------------------
  localparam int PERIOD_W = 12;
  localparam int ANGLE_W  = 9;
  localparam int DUTY_W   = 12;
  localparam int EV_W     = 3;
  localparam int SINE_DEPTH = 96;                                  // one quarter wave
  localparam logic [9:0]  ANGLE_STEPS  = 10'h180;                  // 360 degrees
  localparam logic [9:0]  ANGLE_THIRD  = 10'h080;                  // 120 degrees
  localparam logic [8:0]  ANGLE_LAST   = 9'h17f;
  localparam logic [8:0]  QUARTER      = 9'h060;
  localparam logic [6:0]  SINE_LAST    = 7'h5f;
  localparam logic [11:0] DUTY_MID     = 12'h800;
  localparam logic [7:0]  ANGLE_CONTROL_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST        = 16'h0010;
  localparam logic [11:0] AMPLITUDE_RST     = 12'h000;

  // one-hot calculation states
  typedef enum logic [3:0] {
    CALC_IDLE  = 4'b0001,
    CALC_PHASE = 4'b0010,
    CALC_MOD   = 4'b0100,
    CALC_DONE  = 4'b1000
  } calc_state_t;

  // three phase duty values travel together
  typedef struct packed {
    logic [DUTY_W-1:0] u;
    logic [DUTY_W-1:0] v;
    logic [DUTY_W-1:0] w;
  } duty_t;

endpackage

// *** verification/duty_compare_model.sv ***
// model of the pwm compare registers that take the three duty values
// assumes the load pulse stands one cycle beside settled duty values
`timescale 1ns/1ps
module duty_compare_model
  import angle_calc_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // duty stream from the calculator
  input  wire duty_t i_duty,
  input  wire logic  i_load,
  // compare values held for the pwm counter
  output duty_t      o_cmp,
  output int         o_loads
);
  // ----------------------------------------------------------------
  // compare registers
  // ----------------------------------------------------------------
  // load only on the pulse so a stray duty change never reaches pwm
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmp   <= '0;
      o_loads <= 0;
    end
    else if (i_load)
    begin
      o_cmp   <= i_duty;
      o_loads <= o_loads + 1;
    end
  end
endmodule

// *** verification/angle_waveform_calc_monitor.sv ***
// assertions on the top ports of the angle timer and waveform calculator
// assumes one clock domain and the register map of the package
`timescale 1ns/1ps
module angle_waveform_calc_monitor
  import angle_calc_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // register port
  input  wire logic [15:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [15:0] O_RDATA,
  // pin and results
  input  wire logic        I_POS_DETECT,
  input  wire duty_t       O_DUTY,
  input  wire logic        O_DUTY_LOAD,
  input  wire logic        O_CALC_BUSY,
  input  wire logic        O_IRQ
);
  // ----------------------------------------------------------------
  // shadow copies of what software wrote
  // ----------------------------------------------------------------
  logic [7:0] ac;   // angle control copy
  logic [2:0] mask; // event enable copy
  logic       go;   // start write
  assign go = I_WR && I_ADDR == ADDR_CALC_CONTROL && I_WDATA[CC_START] && !O_CALC_BUSY;
  // copies change on the same edge as the real registers
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ac   <= '0;
      mask <= '0;
    end
    else if (I_WR)
    begin
      if (I_ADDR == ADDR_ANGLE_CONTROL)
        ac <= I_WDATA[7:0];
      if (I_ADDR == ADDR_IRQ_MASK)
        mask <= I_WDATA[2:0];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // five busy cycles, then idle again
  sequence busy_run;
    O_CALC_BUSY [*5] ##1 !O_CALC_BUSY;
  endsequence
  a_read_idle_zero: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_start_busy_run: assert property (go && ac[AC_CALC_EN] |=> busy_run)
    else $error("busy did not follow a start");
  a_calc_load_time: assert property (go && ac[AC_CALC_EN] && ac[AC_XFER] |-> ##6 O_DUTY_LOAD)
    else $error("duty load missing after calculation");
  a_load_needs_xfer: assert property (O_DUTY_LOAD |-> ac[AC_XFER])
    else $error("duty load with transfer off");
  a_duty_hold: assert property (!O_DUTY_LOAD |-> $stable(O_DUTY))
    else $error("duty changed without load");
  a_disabled_no_start: assert property (go && !ac[AC_CALC_EN] |=> !O_CALC_BUSY)
    else $error("calculation ran while disabled");
  a_calc_end_irq: assert property (go && ac[AC_CALC_EN] && I_WDATA[CC_IRQ_SEL] && mask[EV_CALC]
                                   |-> ##6 O_IRQ)
    else $error("no interrupt at calculation end");
  a_irq_masked: assert property (O_IRQ |-> mask != 3'h0)
    else $error("interrupt with all events masked");
  a_capture_irq: assert property ($rose(I_POS_DETECT) && mask[EV_CAP] |-> ##[2:4] O_IRQ)
    else $error("no interrupt after position capture");
endmodule

bind angle_waveform_calc angle_waveform_calc_monitor u_angle_waveform_calc_monitor (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_POS_DETECT(I_POS_DETECT),
  .O_DUTY(O_DUTY), .O_DUTY_LOAD(O_DUTY_LOAD), .O_CALC_BUSY(O_CALC_BUSY), .O_IRQ(O_IRQ));

// *** verification/angle_waveform_calc_bench.sv ***
// self-checking bench for the angle timer and waveform calculator
// assumes a 20 MHz clock and the compare register model on the duty outputs
`timescale 1ns/1ps
module angle_waveform_calc_bench
  import angle_calc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and scenario tables
  // ----------------------------------------------------------------
  logic        clk = 1'b0, rst_n, wr_s, rd_s, pos, load, busy, irq;
  logic [15:0] addr, wdata, rdata;
  duty_t       duty, cmp;   // design output and model copy
  int          loads, n0;   // load count and its value at row start
  int          miscompares = 0;
  int          compares    = 0;
  // sine entries all 0x40, angle 0: offset is amp*0x40>>9
  localparam logic [7:0]  CAC  [4] = '{8'h0e, 8'h4e, 8'h06, 8'h0e};
  localparam logic [15:0] CAMP [4] = '{16'h0200, 16'h0200, 16'h0200, 16'h0400};
  localparam logic [35:0] CEXP [4] = '{36'h8408407c0, 36'h8407c0840, 36'h080080000,
                                       36'h880880780};
  // timer rows: up, down, slowest prescale, correction n of 15
  localparam logic [7:0]  TAC  [4] = '{8'h07, 8'h97, 8'h37, 8'h07};
  localparam logic [15:0] TPER [4] = '{16'h0010, 16'h0010, 16'h0010, 16'hf010};
  localparam int          TWT  [4] = '{389, 389, 2099, 389};
  localparam logic [15:0] TANG [4] = '{16'h0003, 16'h017f, 16'h0002, 16'h0002};
  localparam int          TST  [4] = '{3, 1, 2, 2};

  always #25 clk = ~clk;

  angle_waveform_calc u_angle_waveform_calc (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_POS_DETECT(pos),
    .O_DUTY(duty), .O_DUTY_LOAD(load), .O_CALC_BUSY(busy), .O_IRQ(irq));
  duty_compare_model u_duty_compare_model (.i_clk(clk), .i_rst_n(rst_n), .i_duty(duty),
    .i_load(load), .o_cmp(cmp), .o_loads(loads));

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one-cycle write strobe, taken at the edge after it rises
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the taking edge
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(n, {20'h0, e}, {20'h0, rdata});
  endtask
  task automatic results();
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, wr_s, rd_s, pos, addr, wdata} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_ANGLE_CONTROL, 16'h0000, "angle_control");
    rd(ADDR_ANGLE_PERIOD, 16'h0010, "angle_period");
    rd(16'h1fd0, 16'h0000, "unmapped");
    wr(ADDR_ANGLE_PERIOD, 16'hf123);
    rd(ADDR_ANGLE_PERIOD, 16'hf123, "angle_period");
    wr(ADDR_AMPLITUDE, 16'h0abc);
    rd(ADDR_AMPLITUDE, 16'h0abc, "amplitude");
    wr(ADDR_ANGLE_VALUE, 16'h017f);
    rd(ADDR_ANGLE_VALUE, 16'h017f, "angle_value");
    wr(ADDR_ANGLE_CAPTURE, 16'h1234);
    rd(ADDR_ANGLE_CAPTURE, 16'h0000, "angle_capture");
    // start with calculation disabled must leave the circuit idle
    wr(ADDR_CALC_CONTROL, 16'h000b);
    rd(ADDR_CALC_CONTROL, 16'h0003, "calc_control");
    wr(ADDR_IRQ_MASK, 16'h0007);
    for (int i = 0; i < SINE_DEPTH; i++)
      wr(ADDR_SINE_PORT, 16'h0040);
    wr(ADDR_ANGLE_VALUE, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_ANGLE_CONTROL, {8'h00, CAC[i]});
      wr(ADDR_AMPLITUDE, CAMP[i]);
      wr(ADDR_CALC_CONTROL, 16'h000b);
      rd(ADDR_CALC_CONTROL, 16'h0007, "busy");
      repeat (8) @(posedge clk);
      check("duty", CEXP[i], cmp);
    end
    check("irq", 36'h1, {35'h0, irq});
    // transfer off: calculation runs but compare values stay
    wr(ADDR_ANGLE_CONTROL, 16'h000a);
    wr(ADDR_CALC_CONTROL, 16'h000b);
    repeat (8) @(posedge clk);
    check("loads", 36'd4, loads);
    check("duty", CEXP[3], cmp);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    check("irq", 36'h0, {35'h0, irq});
    // angle-locked automatic starts, one per angle step
    wr(ADDR_CALC_CONTROL, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_ANGLE_VALUE, 16'h0000);
      wr(ADDR_ANGLE_PERIOD, TPER[i]);
      n0 = loads;
      wr(ADDR_ANGLE_CONTROL, {8'h00, TAC[i]});
      repeat (TWT[i]) @(posedge clk);
      rd(ADDR_ANGLE_VALUE, TANG[i], "angle_value");
      wr(ADDR_ANGLE_CONTROL, 16'h0006);
      repeat (8) @(posedge clk);
      check("auto_loads", TST[i], loads - n0);
    end
    check("irq", 36'h1, {35'h0, irq});
    wr(ADDR_ANGLE_VALUE, 16'h0123);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    @(posedge clk);
    pos <= 1'b1;
    repeat (5) @(posedge clk);
    pos <= 1'b0;
    rd(ADDR_ANGLE_CAPTURE, 16'h0123, "angle_capture");
    rd(ADDR_IRQ_STATUS, 16'h0004, "irq_status");
    wr(ADDR_IRQ_MASK, 16'h0003);
    check("irq", 36'h0, {35'h0, irq});
    results();
  end

  // about 3700 cycles expected; cut off well past that
  initial
  begin
    #1000000;
    miscompares++;
    results();
  end
endmodule
